//--- hw/corg_consts.vh
// Constants for the core operational register block.
`ifndef CORG_CONSTS_VH
`define CORG_CONSTS_VH
`define CORG_ADR_WINDOW   8'h00
`define CORG_ADR_BANK     8'h01
`define CORG_ADR_PCL      8'h02
`define CORG_ADR_FLAGS    8'h03
`define CORG_ADR_PTR      8'h04
`define CORG_ADR_P5       8'h05
`define CORG_ADR_P6       8'h06
`define CORG_ADR_P7       8'h07
`define CORG_ADR_P8       8'h08
`define CORG_ADR_P9       8'h09
`define CORG_ADR_PA       8'h0A
`define CORG_ADR_DIR5     8'h0B
`define CORG_ADR_DIR6     8'h0C
`define CORG_ADR_DIR7     8'h0D
`define CORG_ADR_SPEC_LO  8'h05
`define CORG_ADR_SPEC_HI  8'h4F
`define CORG_ADR_GEN_LO   8'h80
`define CORG_BANK_MASK    8'h33
`define CORG_SBANK_HI     5
`define CORG_SBANK_LO     4
`define CORG_GBANK_HI     1
`define CORG_GBANK_LO     0
`define CORG_F_GIE        7
`define CORG_F_NEG        6
`define CORG_F_OVF        5
`define CORG_F_TO         4
`define CORG_F_PD         3
`define CORG_F_Z          2
`define CORG_F_DC         1
`define CORG_F_C          0
`define CORG_FLAGS_RST    8'h18
`define CORG_DIR_RST      8'hFF
`define CORG_ZERO8        8'h00
`define CORG_PC_W         13
`define CORG_PAGE_W       12
`define CORG_PC_RST       13'h0000
`define CORG_PC_ONE       13'h0001
`define CORG_PAGE_WORDS   4096
`define CORG_STACK_D      8
`define CORG_SP_W         3
`define CORG_CLK_PER_CYC  2
`define CORG_CYC_LONG     2
`define CORG_ALU_ADD      3'h0
`define CORG_ALU_SUB      3'h1
`define CORG_ALU_LOGIC    3'h2
`define CORG_ALU_ROT      3'h3
`define CORG_ALU_NONE     3'h4
`endif

//--- hw/corg_port_dir.v
// One eight-bit port data and direction pair with pin synchronisers.
`timescale 1ns/100ps
`include "corg_consts.vh"
module corg_port_dir (
  // Clock and reset.
  input  wire       clk_i,
  input  wire       arst_n_i,
  // Register writes.
  input  wire       data_we_i,
  input  wire       dir_we_i,
  input  wire [7:0] wdata_i,
  // Pins.
  input  wire [7:0] pin_i,
  output reg  [7:0] pin_o,
  output wire [7:0] pin_oe_o,
  // Read back.
  output reg  [7:0] dir_o,
  output wire [7:0] data_rd_o
);
  reg [7:0] sync1;
  reg [7:0] sync2;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_o <= `CORG_ZERO8;
      dir_o <= `CORG_DIR_RST;
      sync1 <= `CORG_ZERO8;
      sync2 <= `CORG_ZERO8;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      if (data_we_i) begin
        pin_o <= wdata_i;
      end
      if (dir_we_i) begin
        dir_o <= wdata_i;
      end
    end
  end
  // A zero direction bit drives the pin; a one leaves it floating.
  assign pin_oe_o  = ~dir_o;
  assign data_rd_o = (pin_oe_o & pin_o) | (dir_o & sync2);
endmodule

//--- hw/corg_regs.v
// Core operational registers: indirect window, banks, counter, flags, ports.
// Functional notes
// - Location zero redirects through the indirect pointer.
// - Special bank field selects banks for R5-R4F.
// - General bank field selects four general banks.
// - Counter low byte clears during reset.
// - Counter spans 8K words in 4096-word pages.
// - In-page branch replaces lower twelve counter bits.
// - In-page call pushes counter plus one, loads twelve.
// - Full-range branch loads lower thirteen counter bits.
// - Full-range call pushes counter plus one, loads thirteen.
// - All returns reload counter from stack top.
// - Accumulator add to low byte carries upward.
// - Other low byte writes keep upper bits.
// - Two clocks per cycle; long ops take two.
// - Interrupt enable: disable/entry clear, enable/interrupt return set.
// - Negative flag copies result top bit.
// - Overflow flag marks two's complement overflow.
// - Timeout bit: set sleep/clear/powerup, cleared by timeout.
// - Power-down bit: set powerup/clear, cleared by sleep.
// - Zero flag set on zero result.
// - Carry: carry on add, no borrow on subtract.
// - Indirect pointer addresses the full 00-FF range.
// - Direction zero drives pin, one floats, default floats.
`timescale 1ns/100ps
`include "corg_consts.vh"
module corg_regs (
  // Clock and reset.
  input  wire        CLK_I,
  input  wire        ARST_N_I,
  // Data access from the execution unit.
  input  wire [7:0]  ADDR_I,
  input  wire        RD_I,
  input  wire        WR_I,
  input  wire [7:0]  WDATA_I,
  output reg  [7:0]  RDATA_O,
  output wire [7:0]  MEM_ADDR_O,
  output wire [1:0]  MEM_BANK_O,
  output wire        MEM_SPECIAL_O,
  output wire        MEM_SEL_O,
  input  wire [7:0]  MEM_RDATA_I,
  // Program counter control.
  input  wire        INSTR_START_I,
  input  wire        BR_PAGE_I,
  input  wire        CALL_PAGE_I,
  input  wire        BR_FAR_I,
  input  wire        CALL_FAR_I,
  input  wire        RET_I,
  input  wire        IRQ_EXIT_I,
  input  wire        PCL_ADD_I,
  input  wire        IRQ_ENTRY_I,
  input  wire [12:0] TARGET_I,
  output reg  [12:0] PC_O,
  output wire        CYCLE_DONE_O,
  // Flag control.
  input  wire [2:0]  ALU_OP_I,
  input  wire [7:0]  ALU_A_I,
  input  wire [7:0]  ALU_B_I,
  input  wire [7:0]  ALU_RES_I,
  input  wire        ROT_CARRY_I,
  input  wire        IRQ_DISABLE_OP_I,
  input  wire        IRQ_ENABLE_OP_I,
  input  wire        POWER_DOWN_OP_I,
  input  wire        WATCHDOG_CLEAR_OP_I,
  input  wire        WATCHDOG_TIMEOUT_I,
  output wire [7:0]  FLAGS_O,
  // Ports 5 to 7.
  input  wire [23:0] PORT_PIN_I,
  output wire [23:0] PORT_PIN_O,
  output wire [23:0] PORT_PIN_OE_O,
  // Ports 8, 9 and A data latches.
  output reg  [23:0] PORT_HI_DATA_O
);
  localparam ST_FIRST  = 2'b01;
  localparam ST_SECOND = 2'b10;

  reg  [7:0]  bank_select;
  reg  [7:0]  core_flags;
  reg  [7:0]  indirect_pointer;
  reg  [12:0] stack_mem [0:`CORG_STACK_D-1];
  reg  [2:0]  sp;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg         phase;
  reg  [12:0] next_pc;
  reg  [7:0]  next_flags;
  reg  [8:0]  sum9;
  reg  [4:0]  sum5;
  reg  [7:0]  next_rdata;
  reg         ovf;
  wire [7:0]  eff_addr;
  wire        pcl_hit;
  wire        long_op;
  wire        exec;
  wire [23:0] dir_all;
  wire [23:0] prt_rd;
  wire [2:0]  sp_top;
  wire [12:0] pc_plus1;
  wire [12:0] pc_add_a;
  integer     i;

  // Accesses to location zero go to the pointed location.
  assign eff_addr = (ADDR_I == `CORG_ADR_WINDOW) ? indirect_pointer : ADDR_I;
  assign pcl_hit  = WR_I && (eff_addr == `CORG_ADR_PCL);
  assign long_op  = BR_FAR_I | CALL_FAR_I | pcl_hit | PCL_ADD_I;
  assign MEM_ADDR_O    = eff_addr;
  assign MEM_BANK_O    = (eff_addr >= `CORG_ADR_GEN_LO) ?
                         bank_select[`CORG_GBANK_HI:`CORG_GBANK_LO] :
                         bank_select[`CORG_SBANK_HI:`CORG_SBANK_LO];
  assign MEM_SPECIAL_O = (eff_addr >= `CORG_ADR_SPEC_LO) && (eff_addr <= `CORG_ADR_SPEC_HI);
  assign MEM_SEL_O     = (eff_addr > `CORG_ADR_DIR7) &&
                         ((eff_addr > `CORG_ADR_SPEC_HI) ||
                          (bank_select[`CORG_SBANK_HI:`CORG_SBANK_LO] != 2'b00));
  assign FLAGS_O  = core_flags;
  assign sp_top   = sp - 3'h1;
  assign pc_plus1 = PC_O + `CORG_PC_ONE;
  assign pc_add_a = PC_O + {5'h00, WDATA_I};

  // Instruction cycle sequencer: two clocks per cycle, two cycles for long ops.
  assign exec         = INSTR_START_I && phase && (state == ST_FIRST);
  assign CYCLE_DONE_O = phase && ((state == ST_SECOND) || (state == ST_FIRST &&
                        !(INSTR_START_I && long_op)));
  always @* begin
    case (state)
      ST_FIRST: begin
        next_state = (phase && INSTR_START_I && long_op) ? ST_SECOND : ST_FIRST;
      end
      ST_SECOND: begin
        next_state = phase ? ST_FIRST : ST_SECOND;
      end
      default: begin
        next_state = ST_FIRST;
      end
    endcase
  end

  // Program counter next value.
  always @* begin
    next_pc = PC_O;
    if (exec) begin
      if (BR_PAGE_I || CALL_PAGE_I) begin
        next_pc = {PC_O[`CORG_PC_W-1:`CORG_PAGE_W],
                   TARGET_I[`CORG_PAGE_W-1:0]};
      end else if (BR_FAR_I || CALL_FAR_I) begin
        next_pc = TARGET_I;
      end else if (RET_I || IRQ_EXIT_I) begin
        next_pc = stack_mem[sp_top];
      end else if (PCL_ADD_I) begin
        next_pc = pc_add_a;
      end else if (pcl_hit) begin
        next_pc = {PC_O[`CORG_PC_W-1:8], WDATA_I};
      end else begin
        next_pc = pc_plus1;
      end
    end
  end

  // Flag next value.
  always @* begin
    next_flags = core_flags;
    sum9 = {1'b0, ALU_A_I} + {1'b0, ALU_B_I};
    sum5 = {1'b0, ALU_A_I[3:0]} + {1'b0, ALU_B_I[3:0]};
    ovf  = 1'b0;
    if (exec) begin
      case (ALU_OP_I)
        `CORG_ALU_ADD: begin
          ovf  = (ALU_A_I[7] == ALU_B_I[7]) && (ALU_RES_I[7] != ALU_A_I[7]);
          next_flags[`CORG_F_C]  = sum9[8];
          next_flags[`CORG_F_DC] = sum5[4];
        end
        `CORG_ALU_SUB: begin
          ovf  = (ALU_A_I[7] != ALU_B_I[7]) && (ALU_RES_I[7] != ALU_A_I[7]);
          next_flags[`CORG_F_C]  = (ALU_A_I >= ALU_B_I);
          next_flags[`CORG_F_DC] = (ALU_A_I[3:0] >= ALU_B_I[3:0]);
        end
        `CORG_ALU_ROT: begin
          next_flags[`CORG_F_C] = ROT_CARRY_I;
        end
        default: begin
          ovf = 1'b0;
        end
      endcase
      if (ALU_OP_I != `CORG_ALU_NONE) begin
        next_flags[`CORG_F_NEG] = ALU_RES_I[7];
        next_flags[`CORG_F_OVF] = ovf;
        next_flags[`CORG_F_Z]   = (ALU_RES_I == `CORG_ZERO8);
      end
      if (IRQ_DISABLE_OP_I) begin
        next_flags[`CORG_F_GIE] = 1'b0;
      end
      if (IRQ_ENABLE_OP_I || IRQ_EXIT_I) begin
        next_flags[`CORG_F_GIE] = 1'b1;
      end
      if (POWER_DOWN_OP_I) begin
        next_flags[`CORG_F_TO] = 1'b1;
        next_flags[`CORG_F_PD] = 1'b0;
      end
      if (WATCHDOG_CLEAR_OP_I) begin
        next_flags[`CORG_F_TO] = 1'b1;
        next_flags[`CORG_F_PD] = 1'b1;
      end
      if (WR_I && eff_addr == `CORG_ADR_FLAGS) begin
        next_flags[`CORG_F_NEG:0] = WDATA_I[`CORG_F_NEG:0];
      end
    end
    if (IRQ_ENTRY_I) begin
      next_flags[`CORG_F_GIE] = 1'b0;
    end
    if (WATCHDOG_TIMEOUT_I) begin
      next_flags[`CORG_F_TO] = 1'b0;
    end
  end

  // Clocked state.
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state            <= ST_FIRST;
      phase            <= 1'b0;
      PC_O             <= `CORG_PC_RST;
      bank_select      <= `CORG_ZERO8;
      core_flags       <= `CORG_FLAGS_RST;
      indirect_pointer <= `CORG_ZERO8;
      sp               <= 3'h0;
      PORT_HI_DATA_O   <= 24'h000000;
      for (i = 0; i < `CORG_STACK_D; i = i + 1) begin
        stack_mem[i] <= `CORG_PC_RST;
      end
    end else begin
      phase      <= ~phase;
      state      <= next_state;
      PC_O       <= next_pc;
      core_flags <= next_flags;
      if (exec && (CALL_PAGE_I || CALL_FAR_I)) begin
        stack_mem[sp] <= pc_plus1;
        sp            <= sp + 3'h1;
      end else if (exec && (RET_I || IRQ_EXIT_I)) begin
        sp <= sp_top;
      end
      if (exec && WR_I) begin
        if (eff_addr == `CORG_ADR_BANK) begin
          bank_select <= WDATA_I & `CORG_BANK_MASK;
        end
        if (eff_addr == `CORG_ADR_PTR) begin
          indirect_pointer <= WDATA_I;
        end
        if (eff_addr == `CORG_ADR_P8) begin
          PORT_HI_DATA_O[7:0] <= WDATA_I;
        end
        if (eff_addr == `CORG_ADR_P9) begin
          PORT_HI_DATA_O[15:8] <= WDATA_I;
        end
        if (eff_addr == `CORG_ADR_PA) begin
          PORT_HI_DATA_O[23:16] <= WDATA_I;
        end
      end
    end
  end

  // Read data register.
  always @* begin
    case (eff_addr)
      `CORG_ADR_BANK:  next_rdata = bank_select;
      `CORG_ADR_PCL:   next_rdata = PC_O[7:0];
      `CORG_ADR_FLAGS: next_rdata = core_flags;
      `CORG_ADR_PTR:   next_rdata = indirect_pointer;
      `CORG_ADR_P5:    next_rdata = prt_rd[7:0];
      `CORG_ADR_P6:    next_rdata = prt_rd[15:8];
      `CORG_ADR_P7:    next_rdata = prt_rd[23:16];
      `CORG_ADR_P8:    next_rdata = PORT_HI_DATA_O[7:0];
      `CORG_ADR_P9:    next_rdata = PORT_HI_DATA_O[15:8];
      `CORG_ADR_PA:    next_rdata = PORT_HI_DATA_O[23:16];
      `CORG_ADR_DIR5:  next_rdata = dir_all[7:0];
      `CORG_ADR_DIR6:  next_rdata = dir_all[15:8];
      `CORG_ADR_DIR7:  next_rdata = dir_all[23:16];
      default:         next_rdata = MEM_RDATA_I;
    endcase
  end

  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      RDATA_O <= `CORG_ZERO8;
    end else if (RD_I) begin
      RDATA_O <= next_rdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_port
      corg_port_dir u_port (
        .clk_i     (CLK_I),
        .arst_n_i  (ARST_N_I),
        .data_we_i (exec && WR_I && (eff_addr == `CORG_ADR_P5 + g)),
        .dir_we_i  (exec && WR_I && (eff_addr == `CORG_ADR_DIR5 + g)),
        .wdata_i   (WDATA_I),
        .pin_i     (PORT_PIN_I[g*8+7:g*8]),
        .pin_o     (PORT_PIN_O[g*8+7:g*8]),
        .pin_oe_o  (PORT_PIN_OE_O[g*8+7:g*8]),
        .dir_o     (dir_all[g*8+7:g*8]),
        .data_rd_o (prt_rd[g*8+7:g*8])
      );
    end
  endgenerate
endmodule

//--- verification/corg_regs_sva.sv
// Checker for the core operational register block ports.
`timescale 1ns/100ps
module corg_regs_sva (
  // Observed ports.
  input wire        CLK_I,
  input wire        ARST_N_I,
  input wire [7:0]  ADDR_I,
  input wire        WR_I,
  input wire [7:0]  WDATA_I,
  input wire        INSTR_START_I,
  input wire        BR_PAGE_I,
  input wire        BR_FAR_I,
  input wire        CALL_FAR_I,
  input wire        PCL_ADD_I,
  input wire        IRQ_ENTRY_I,
  input wire        IRQ_ENABLE_OP_I,
  input wire        POWER_DOWN_OP_I,
  input wire        WATCHDOG_TIMEOUT_I,
  input wire [12:0] TARGET_I,
  input wire [12:0] PC_O,
  input wire        CYCLE_DONE_O,
  input wire [2:0]  ALU_OP_I,
  input wire [7:0]  ALU_RES_I,
  input wire [7:0]  FLAGS_O,
  input wire [23:0] PORT_PIN_OE_O
);
  wire fin = CYCLE_DONE_O;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  // A long instruction is refused completion for two clocks, then completes within two more.
  sequence long_issue;
    $rose(INSTR_START_I) && (BR_FAR_I || CALL_FAR_I || PCL_ADD_I);
  endsequence
  sequence long_finish;
    !fin [*2] ##[1:2] fin;
  endsequence
  reset_vals_a: assert property (
    $rose(ARST_N_I) |-> PC_O == 13'h0000 && FLAGS_O == 8'h18 && PORT_PIN_OE_O == 24'h000000)
    else $error("reset values wrong");
  done_gap_a: assert property (fin |=> !fin)
    else $error("instruction shorter than two clocks");
  long_op_a: assert property (long_issue |-> long_finish)
    else $error("long instruction length wrong");
  far_branch_a: assert property (fin && BR_FAR_I |=> PC_O == $past(TARGET_I))
    else $error("far branch target wrong");
  page_branch_a: assert property (
    fin && BR_PAGE_I |=> PC_O[11:0] == $past(TARGET_I[11:0]) && $stable(PC_O[12]))
    else $error("page branch target wrong");
  pcl_write_a: assert property (
    fin && WR_I && ADDR_I == 8'h02 && !PCL_ADD_I |=> PC_O == {$past(PC_O[12:8]), $past(WDATA_I)})
    else $error("low byte write disturbed upper counter");
  gie_set_a: assert property (fin && IRQ_ENABLE_OP_I && !IRQ_ENTRY_I |=> FLAGS_O[7])
    else $error("enable op left interrupts off");
  sleep_flags_a: assert property (
    fin && POWER_DOWN_OP_I && !WATCHDOG_TIMEOUT_I |=> FLAGS_O[4:3] == 2'b10)
    else $error("power down flags wrong");
  wdt_clear_a: assert property (WATCHDOG_TIMEOUT_I |=> !FLAGS_O[4])
    else $error("timeout bit not cleared");
  add_flags_a: assert property (
    fin && ALU_OP_I == 3'h0 |=> FLAGS_O[6] == $past(ALU_RES_I[7])
      && FLAGS_O[2] == ($past(ALU_RES_I) == 8'h00))
    else $error("negative or zero flag wrong");
  dir_oe_a: assert property (
    fin && WR_I && ADDR_I == 8'h0B |=> PORT_PIN_OE_O[7:0] == ~$past(WDATA_I))
    else $error("port enable does not follow direction");
endmodule

//--- verification/corg_exu_model.sv
// Execution unit model that presents instructions and waits for completion.
`timescale 1ns/100ps
module corg_exu_model (
  // Clock and handshake.
  input  wire        clk_i,
  input  wire        done_i,
  output reg         start_o = 1'b0,
  // Instruction fields, held until the instruction completes.
  output reg  [12:0] ctl_o = 13'h0000,
  output reg  [7:0]  addr_o = 8'h00,
  output reg  [7:0]  wdata_o = 8'h00,
  output reg  [12:0] target_o = 13'h0000,
  // Data memory.
  input  wire [7:0]  mem_addr_i,
  output wire [7:0]  mem_rdata_o
);
  integer k;
  // Each location holds the inverse of its address, so reads are traceable.
  assign mem_rdata_o = ~mem_addr_i;
  task run(input [12:0] c, input [7:0] a, input [7:0] d, input [12:0] t, output reg ok);
    ok = 1'b0;
    @(posedge clk_i);
    #1;
    start_o = 1'b1;
    ctl_o = c;
    addr_o = a;
    wdata_o = d;
    target_o = t;
    for (k = 0; k < 8 && !ok; k = k + 1) begin
      @(negedge clk_i);
      ok = (done_i === 1'b1);
    end
    @(posedge clk_i);
    #1;
    start_o = 1'b0;
    ctl_o = 13'h0000;
  endtask
endmodule

//--- verification/corg_regs_tb.sv
// Testbench for the core operational register block.
`timescale 1ns/100ps
module corg_regs_tb;
  localparam [12:0] op_wr = 13'h0001, op_rd = 13'h0002, op_bp = 13'h0004, op_cp = 13'h0008;
  localparam [12:0] op_bf = 13'h0010, op_cf = 13'h0020, op_rt = 13'h0040, op_ri = 13'h0080;
  localparam [12:0] op_pa = 13'h0100, op_di = 13'h0200, op_en = 13'h0400, op_pd = 13'h0800;
  localparam [12:0] op_wc = 13'h1000;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [2:0]  alu_op = 3'h4;
  reg  [7:0]  alu_a = 8'h00, alu_b = 8'h00, alu_r = 8'h00;
  reg         rot_c = 1'b0, irq_in = 1'b0, wdt_to = 1'b0, ok;
  reg  [23:0] pins = 24'h3C3C3C;
  wire        start, done, spec, sel;
  wire [12:0] ctl, tgt, pc;
  wire [7:0]  addr, wd, rd, maddr, mrd, flags;
  wire [1:0]  bank;
  wire [23:0] p_o, p_oe, p_hi;
  integer     n_errors = 0, num_checks = 0;
  initial forever #5 clk = ~clk;
  corg_regs dut (.CLK_I(clk), .ARST_N_I(rst_n), .ADDR_I(addr), .RD_I(ctl[1]), .WR_I(ctl[0]),
    .WDATA_I(wd), .RDATA_O(rd), .MEM_ADDR_O(maddr), .MEM_BANK_O(bank), .MEM_SPECIAL_O(spec),
    .MEM_SEL_O(sel), .MEM_RDATA_I(mrd), .INSTR_START_I(start), .BR_PAGE_I(ctl[2]),
    .CALL_PAGE_I(ctl[3]), .BR_FAR_I(ctl[4]), .CALL_FAR_I(ctl[5]), .RET_I(ctl[6]),
    .IRQ_EXIT_I(ctl[7]), .PCL_ADD_I(ctl[8]), .IRQ_ENTRY_I(irq_in), .TARGET_I(tgt), .PC_O(pc),
    .CYCLE_DONE_O(done), .ALU_OP_I(alu_op), .ALU_A_I(alu_a), .ALU_B_I(alu_b), .ALU_RES_I(alu_r),
    .ROT_CARRY_I(rot_c), .IRQ_DISABLE_OP_I(ctl[9]), .IRQ_ENABLE_OP_I(ctl[10]),
    .POWER_DOWN_OP_I(ctl[11]), .WATCHDOG_CLEAR_OP_I(ctl[12]), .WATCHDOG_TIMEOUT_I(wdt_to),
    .FLAGS_O(flags), .PORT_PIN_I(pins), .PORT_PIN_O(p_o), .PORT_PIN_OE_O(p_oe),
    .PORT_HI_DATA_O(p_hi));
  corg_exu_model exu (.clk_i(clk), .done_i(done), .start_o(start), .ctl_o(ctl), .addr_o(addr),
    .wdata_o(wd), .target_o(tgt), .mem_addr_i(maddr), .mem_rdata_o(mrd));
  task chk(input string n, input [23:0] e, input [23:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // A missing completion ends the run at once rather than hanging.
  task go(input [12:0] c, input [7:0] a, input [7:0] d, input [12:0] t);
    exu.run(c, a, d, t, ok);
    if (ok !== 1'b1) begin
      chk("done", 1'b1, 1'b0);
      report_and_stop;
    end
  endtask
  task op(input [12:0] c, input [7:0] a, input [7:0] d);
    go(c, a, d, 13'h0000);
  endtask
  task pulse(input reg w);
    @(posedge clk);
    #1;
    if (w) wdt_to = 1'b1;
    else irq_in = 1'b1;
    @(posedge clk);
    #1;
    wdt_to = 1'b0;
    irq_in = 1'b0;
  endtask
  task do_reset;
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    chk("pc", 13'h0000, pc);
    chk("flags", 8'h18, flags);
    chk("oe", 24'h000000, p_oe);
    #1;
    rst_n = 1'b1;
  endtask
  task t_banks;
    op(op_wr, 8'h01, 8'hFF);
    op(op_rd, 8'h01, 8'h00);
    chk("bank_rd", 8'h33, rd);
    op(op_wr, 8'h01, 8'h12);
    op(13'h0000, 8'h90, 8'h00);
    chk("gen_bank", 2'h2, bank);
    op(13'h0000, 8'h4F, 8'h00);
    chk("spec_bank", 3'h5, {spec, bank});
  endtask
  task t_ind;
    op(op_wr, 8'h04, 8'hA5);
    op(op_rd, 8'h00, 8'h00);
    chk("ind_mem", 17'h1A55A, {sel, maddr, rd});
    op(op_wr, 8'h04, 8'hFF);
    op(op_rd, 8'h00, 8'h00);
    chk("ind_top", 17'h1FF00, {sel, maddr, rd});
    op(op_wr, 8'h04, 8'h01);
    op(op_rd, 8'h00, 8'h00);
    chk("ind_reg", 8'h12, rd);
  endtask
  task fl(input [2:0] o, input [7:0] a, input [7:0] b, input [7:0] r, input [6:0] e,
          input [6:0] m);
    alu_op = o;
    alu_a = a;
    alu_b = b;
    alu_r = r;
    rot_c = (o == 3'h3);
    op(13'h0000, 8'h50, 8'h00);
    chk("flags", e, flags[6:0] & m);
    alu_op = 3'h4;
  endtask
  task t_pc;
    go(op_bf, 8'h50, 8'h00, 13'h1FF0);
    chk("pc_far", 13'h1FF0, pc);
    go(op_bp, 8'h50, 8'h00, 13'h0123);
    chk("pc_page", 13'h1123, pc);
    go(op_cf, 8'h50, 8'h00, 13'h0800);
    go(op_cp, 8'h50, 8'h00, 13'h0FFF);
    chk("pc_call", 13'h0FFF, pc);
    op(op_ri, 8'h50, 8'h00);
    chk("pc_irq_exit", 14'h2801, {flags[7], pc});
    op(op_rt, 8'h50, 8'h00);
    chk("pc_ret", 13'h1124, pc);
    op(op_wr, 8'h02, 8'h34);
    chk("pc_mov", 13'h1134, pc);
    op(op_wr | op_pa, 8'h02, 8'hF0);
    chk("pc_add", 13'h1224, pc);
  endtask
  task t_status;
    op(op_en, 8'h50, 8'h00);
    chk("gie_on", 1'b1, flags[7]);
    pulse(1'b0);
    chk("gie_irq", 1'b0, flags[7]);
    op(op_en, 8'h50, 8'h00);
    op(op_di, 8'h50, 8'h00);
    chk("gie_off", 1'b0, flags[7]);
    op(op_pd, 8'h50, 8'h00);
    chk("sleep", 2'h2, flags[4:3]);
    pulse(1'b1);
    chk("wdt_to", 2'h0, flags[4:3]);
    op(op_wc, 8'h50, 8'h00);
    chk("wdt_clr", 2'h3, flags[4:3]);
  endtask
  task t_ports;
    op(op_wr, 8'h0B, 8'h0F);
    op(op_wr, 8'h0C, 8'h00);
    op(op_wr, 8'h0D, 8'h80);
    chk("oe", 24'h7FFFF0, p_oe);
    op(op_wr, 8'h05, 8'hA5);
    op(op_rd, 8'h05, 8'h00);
    chk("p5", 16'hA5AC, {p_o[7:0], rd});
    op(op_wr, 8'h08, 8'h11);
    op(op_wr, 8'h09, 8'h22);
    op(op_wr, 8'h0A, 8'h33);
    op(op_wr, 8'h04, 8'h09);
    op(op_wr, 8'h00, 8'h44);
    chk("hi_data", 24'h334411, p_hi);
  endtask
  initial begin
    do_reset;
    t_banks;
    t_ind;
    fl(3'h0, 8'h7F, 8'h01, 8'h80, 7'h7A, 7'h7F);
    fl(3'h1, 8'h05, 8'h05, 8'h00, 7'h1F, 7'h7F);
    fl(3'h1, 8'h00, 8'h01, 8'hFF, 7'h58, 7'h7F);
    fl(3'h1, 8'h80, 8'h01, 8'h7F, 7'h39, 7'h7F);
    fl(3'h3, 8'h81, 8'h00, 8'h03, 7'h01, 7'h01);
    fl(3'h2, 8'hF0, 8'h0F, 8'h00, 7'h1D, 7'h7F);
    t_pc;
    t_status;
    t_ports;
    do_reset;
    report_and_stop;
  end
endmodule
bind corg_regs corg_regs_sva chk_i (.*);
